// ===== logic/qpt_pwm_timer.sv
// Behaviour
// - four channels, 16-bit counter, comparator, interrupt
// - channels 0,1 and 2,3 share prescalers
// - selector divides by 1,2,4,8,16
// - output level changes at compare match
// - enabled dead zone drives both pair pins
// - dead zone 0 pair 0,1; 1 pair 2,3
// - reload and compare are double-buffered
// - new reload applies from next period
// - counter reaching zero requests an interrupt
// - toggle mode reloads and continues at zero
// - one-shot stops at zero, one interrupt
// - live count readable apart from reload
// - reload copies reload value into counter
// - zero reload halts; disabling stops at once
// - capture latches count on rise, fall
// - separate rise and fall capture interrupt enables
// - capture interrupt reloads its channel counter
// - four interrupt lines, pwm and capture shared
// - prescaler divides by value plus one; zero stops it
// - 8-bit dead-zone gap at rising edges
`timescale 1ns/100ps
`include "qpt_defs.svh"
module qpt_pwm_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // pins
  input wire logic [3:0] cap_in,
  output logic [3:0] pwm_out,
  // interrupt lines
  output logic [3:0] irq
);
  // ****************************************
  // state
  // ****************************************
  logic [31:0] presc_r;
  logic [15:0] csr_r;
  logic [31:0] tctl_r;
  qpt_pkg::qpt_cnt_t reload_r [4];
  qpt_pkg::qpt_cnt_t cmp_buf_r [4];
  qpt_pkg::qpt_cnt_t cmp_act_r [4];
  qpt_pkg::qpt_cnt_t cnt_r [4];
  qpt_pkg::qpt_cnt_t rlat_r [4];
  qpt_pkg::qpt_cnt_t flat_r [4];
  logic [3:0] run_r, en_q_r, mod_q_r;
  logic [3:0] timer_irq_enable_r, pflag_r, pin_en_r, capen_r;
  logic [3:0] rie_r, fie_r, rflag_r, fflag_r;
  logic [3:0] cap_s1_r, cap_s2_r, cap_s3_r;
  logic [3:0] pwm_out_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] en, inv, mode, tick, start, zero_ev, lvl, pin_lvl;
  logic [3:0] rise_ev, fall_ev, cap_reload, mod_rise;
  logic [1:0] dzen, dz_a, dz_b;

  // address of a per-channel register
  function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] ofs);
    ch_addr = 8'(`QPT_CH_BASE + `QPT_CH_STRIDE * ch + ofs);
  endfunction : ch_addr

  // address of a capture latch
  function automatic logic [7:0] lat_addr(input int ch, input logic [7:0] ofs);
    lat_addr = 8'(`QPT_LATCH_BASE + `QPT_LATCH_STRIDE * ch + ofs);
  endfunction : lat_addr

  // bit of a channel in a capture control register
  function automatic int ccr_bit(input int ch, input int pos);
    ccr_bit = (ch % 2) * `QPT_CCR_HALF + pos;
  endfunction : ccr_bit

  // ****************************************
  // channel controls
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      en[i] = tctl_r[i * `QPT_TCTL_CH_STRIDE + `QPT_TCTL_EN];
      inv[i] = tctl_r[i * `QPT_TCTL_CH_STRIDE + `QPT_TCTL_INV];
      mode[i] = tctl_r[i * `QPT_TCTL_CH_STRIDE + `QPT_TCTL_MOD];
    end
  end
  assign dzen = tctl_r[`QPT_TCTL_DZEN + 1:`QPT_TCTL_DZEN];
  assign start = en & ~en_q_r;
  assign mod_rise = mode & ~mod_q_r;

  // one prescaler and two selectors per pair
  qpt_clkgen u_clk_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .prescale(presc_r[7:0]),
    .sel_a(csr_r[2:0]),
    .sel_b(csr_r[6:4]),
    .tick(tick[1:0])
  );
  qpt_clkgen u_clk_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .prescale(presc_r[15:8]),
    .sel_a(csr_r[10:8]),
    .sel_b(csr_r[14:12]),
    .tick(tick[3:2])
  );

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_r <= `QPT_RST;
      csr_r <= 16'h0000;
      tctl_r <= `QPT_RST;
      timer_irq_enable_r <= 4'h0;
      pin_en_r <= 4'h0;
      capen_r <= 4'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `QPT_PRESC)
        presc_r <= reg_wdata;
      if (reg_addr == `QPT_CSR)
        csr_r <= reg_wdata[15:0] & 16'h7777;
      if (reg_addr == `QPT_TCTL)
        tctl_r <= reg_wdata & 32'h0D0D_0D3D;
      if (reg_addr == `QPT_IRQ_EN)
        timer_irq_enable_r <= reg_wdata[3:0];
      if (reg_addr == `QPT_PIN_EN)
        pin_en_r <= reg_wdata[3:0];
      if (reg_addr == `QPT_CAP_EN)
        capen_r <= reg_wdata[3:0];
    end
  end

  // buffered reload and compare values; mode rise clears both
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        reload_r[i] <= 16'h0000;
        cmp_buf_r[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (mod_rise[i])
        begin
          reload_r[i] <= 16'h0000;
          cmp_buf_r[i] <= 16'h0000;
        end
        else if (reg_wr && reg_addr == ch_addr(i, `QPT_RELOAD_OFS))
          reload_r[i] <= reg_wdata[15:0];
        else if (reg_wr && reg_addr == ch_addr(i, `QPT_COMPARE_OFS))
          cmp_buf_r[i] <= reg_wdata[15:0];
      end
    end
  end

  // ****************************************
  // down-counters
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      zero_ev[i] = en[i] & ~start[i] & ~cap_reload[i] & run_r[i] & tick[i] & (cnt_r[i] == 16'h0000);
  end

  // counting, reload at zero and capture reload
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r <= 4'h0;
      en_q_r <= 4'h0;
      mod_q_r <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
        cnt_r[i] <= 16'h0000;
        cmp_act_r[i] <= 16'h0000;
      end
    end
    else
    begin
      en_q_r <= en;
      mod_q_r <= mode;
      for (int i = 0; i < 4; i++)
      begin
        if (!en[i])
          run_r[i] <= 1'b0;
        else if (start[i] || cap_reload[i])
        begin
          cnt_r[i] <= reload_r[i];
          cmp_act_r[i] <= cmp_buf_r[i];
          run_r[i] <= 1'b1;
        end
        else if (zero_ev[i])
        begin
          if (mode[i] && reload_r[i] != 16'h0000)
          begin
            cnt_r[i] <= reload_r[i];
            cmp_act_r[i] <= cmp_buf_r[i];
          end
          else
            run_r[i] <= 1'b0;
        end
        else if (run_r[i] && tick[i])
          cnt_r[i] <= cnt_r[i] - 16'h0001;
      end
    end
  end

  // timer interrupt flags; a new event wins over a clear by zero write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pflag_r <= 4'h0;
    else if (reg_wr && reg_addr == `QPT_IRQ_FLAG)
      pflag_r <= (pflag_r & reg_wdata[3:0]) | zero_ev;
    else
      pflag_r <= pflag_r | zero_ev;
  end

  // ****************************************
  // capture
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_s1_r <= 4'h0;
      cap_s2_r <= 4'h0;
      cap_s3_r <= 4'h0;
    end
    else
    begin
      cap_s1_r <= cap_in;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end
  assign rise_ev = capen_r & cap_s2_r & ~cap_s3_r;
  assign fall_ev = capen_r & ~cap_s2_r & cap_s3_r;
  assign cap_reload = (rise_ev & rie_r) | (fall_ev & fie_r);

  // capture latches
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rlat_r[i] <= 16'h0000;
        flat_r[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (rise_ev[i])
          rlat_r[i] <= cnt_r[i];
        if (fall_ev[i])
          flat_r[i] <= cnt_r[i];
      end
    end
  end

  // capture enables and flags; write one clears, an edge wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rie_r <= 4'h0;
      fie_r <= 4'h0;
      rflag_r <= 4'h0;
      fflag_r <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (reg_wr && reg_addr == (i < 2 ? `QPT_CAP_CTRL_A : `QPT_CAP_CTRL_B))
        begin
          rie_r[i] <= reg_wdata[ccr_bit(i, `QPT_CCR_RIE)];
          fie_r[i] <= reg_wdata[ccr_bit(i, `QPT_CCR_FIE)];
          rflag_r[i] <= (rflag_r[i] & ~reg_wdata[ccr_bit(i, `QPT_CCR_RFLAG)]) | rise_ev[i];
          fflag_r[i] <= (fflag_r[i] & ~reg_wdata[ccr_bit(i, `QPT_CCR_FFLAG)]) | fall_ev[i];
        end
        else
        begin
          rflag_r[i] <= rflag_r[i] | rise_ev[i];
          fflag_r[i] <= fflag_r[i] | fall_ev[i];
        end
      end
    end
  end

  // one line per channel, timer and capture sharing it
  assign irq = (pflag_r & timer_irq_enable_r) | (rflag_r & rie_r) | (fflag_r & fie_r);

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      lvl[i] = (run_r[i] & (cnt_r[i] <= cmp_act_r[i])) ^ inv[i];
  end

  // pair 0,1 and pair 2,3 each have their own generator
  qpt_deadzone u_dz_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lvl(lvl[0]),
    .tick(tick[0]),
    .len(presc_r[23:16]),
    .out_a(dz_a[0]),
    .out_b(dz_b[0])
  );
  qpt_deadzone u_dz_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lvl(lvl[2]),
    .tick(tick[2]),
    .len(presc_r[31:24]),
    .out_a(dz_a[1]),
    .out_b(dz_b[1])
  );

  // dead zone takes over both pins of its pair
  assign pin_lvl[1:0] = dzen[0] ? {dz_b[0], dz_a[0]} : lvl[1:0];
  assign pin_lvl[3:2] = dzen[1] ? {dz_b[1], dz_a[1]} : lvl[3:2];

  // pins held low unless output enabled
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_out_r <= 4'h0;
    else
      pwm_out_r <= pin_lvl & pin_en_r;
  end
  assign pwm_out = pwm_out_r;

  // ****************************************
  // register read
  // ****************************************
  always_comb
  begin
    rdata_nxt = `QPT_RST;
    unique case (reg_addr)
      `QPT_PRESC: rdata_nxt = presc_r;
      `QPT_CSR: rdata_nxt = {16'h0000, csr_r};
      `QPT_TCTL: rdata_nxt = tctl_r;
      `QPT_IRQ_EN: rdata_nxt = {28'h0000000, timer_irq_enable_r};
      `QPT_IRQ_FLAG: rdata_nxt = {28'h0000000, pflag_r};
      `QPT_CAP_EN: rdata_nxt = {28'h0000000, capen_r};
      `QPT_PIN_EN: rdata_nxt = {28'h0000000, pin_en_r};
      default: rdata_nxt = `QPT_RST;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (reg_addr == ch_addr(i, `QPT_RELOAD_OFS))
        rdata_nxt = {16'h0000, reload_r[i]};
      if (reg_addr == ch_addr(i, `QPT_COMPARE_OFS))
        rdata_nxt = {16'h0000, cmp_buf_r[i]};
      if (reg_addr == ch_addr(i, `QPT_LIVE_OFS))
        rdata_nxt = {16'h0000, cnt_r[i]};
      if (reg_addr == lat_addr(i, 8'h00))
        rdata_nxt = {16'h0000, rlat_r[i]};
      if (reg_addr == lat_addr(i, `QPT_FALL_OFS))
        rdata_nxt = {16'h0000, flat_r[i]};
    end
    for (int i = 0; i < 4; i++)
    begin
      if (reg_addr == (i < 2 ? `QPT_CAP_CTRL_A : `QPT_CAP_CTRL_B))
      begin
        rdata_nxt[ccr_bit(i, `QPT_CCR_RIE)] = rie_r[i];
        rdata_nxt[ccr_bit(i, `QPT_CCR_FIE)] = fie_r[i];
        rdata_nxt[ccr_bit(i, `QPT_CCR_RFLAG)] = rflag_r[i];
        rdata_nxt[ccr_bit(i, `QPT_CCR_FFLAG)] = fflag_r[i];
      end
    end
  end

  // read data for one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= `QPT_RST;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= `QPT_RST;
  end
  assign reg_rdata = rdata_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < 4; g++)
  begin : g_chk
    toggle_reload_a: assert property (zero_ev[g] && mode[g] && reload_r[g] != 16'h0000
      |=> run_r[g] && cnt_r[g] == $past(reload_r[g]) && cmp_act_r[g] == $past(cmp_buf_r[g]))
      else $error("toggle reload wrong");
    oneshot_stop_a: assert property (zero_ev[g] && !mode[g] |=> !run_r[g] ##1 !zero_ev[g])
      else $error("one-shot did not stop");
    zero_irq_a: assert property (zero_ev[g] |=> pflag_r[g] ##0 (timer_irq_enable_r[g] -> irq[g]))
      else $error("zero gave no request");
    count_down_a: assert property (run_r[g] && tick[g] && en[g] && !start[g] && !cap_reload[g]
      && cnt_r[g] != 16'h0000 |=> cnt_r[g] == $past(cnt_r[g]) - 16'h0001)
      else $error("counter did not decrement");
    halt_now_a: assert property (run_r[g] && !en[g] |=> !run_r[g] && $stable(cnt_r[g]))
      else $error("disabled timer kept running");
    pin_gate_a: assert property (!pin_en_r[g] |=> !pwm_out[g])
      else $error("pin driven while disabled");
    rise_latch_a: assert property (rise_ev[g] |=> rlat_r[g] == $past(cnt_r[g]))
      else $error("rise latch missed count");
    cap_reload_a: assert property (rise_ev[g] && rie_r[g] && en[g] |=> cnt_r[g] == $past(reload_r[g])
      && irq[g]) else $error("capture did not reload");
    cmp_hold_a: assert property ($changed(cmp_act_r[g]) |-> $past(start[g]) || $past(cap_reload[g])
      || $past(zero_ev[g])) else $error("compare changed mid-period");
  end

  toggle_run_c: cover property (zero_ev[0] && mode[0] ##[1:200] zero_ev[0]);
  oneshot_c: cover property (zero_ev[1] && !mode[1]);
  capture_c: cover property (rise_ev[2] ##[1:200] fall_ev[2]);
  deadzone_c: cover property (dzen[0] && pwm_out[0] ##[1:300] pwm_out[1]);
endmodule : qpt_pwm_timer

// ===== include/qpt_defs.svh
`ifndef QPT_DEFS_SVH
`define QPT_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define QPT_PRESC 8'h00
`define QPT_CSR 8'h04
`define QPT_TCTL 8'h08
`define QPT_CH_BASE 8'h0C
`define QPT_CH_STRIDE 8'h0C
`define QPT_RELOAD_OFS 8'h00
`define QPT_COMPARE_OFS 8'h04
`define QPT_LIVE_OFS 8'h08
`define QPT_IRQ_EN 8'h40
`define QPT_IRQ_FLAG 8'h44
`define QPT_CAP_CTRL_A 8'h50
`define QPT_CAP_CTRL_B 8'h54
`define QPT_LATCH_BASE 8'h58
`define QPT_LATCH_STRIDE 8'h08
`define QPT_FALL_OFS 8'h04
`define QPT_CAP_EN 8'h78
`define QPT_PIN_EN 8'h7C
// ****************************************
// field positions and reset value
// ****************************************
`define QPT_FIELD_W 8
`define QPT_DIV_STRIDE 4
`define QPT_TCTL_CH_STRIDE 8
`define QPT_TCTL_EN 0
`define QPT_TCTL_INV 2
`define QPT_TCTL_MOD 3
`define QPT_TCTL_DZEN 4
`define QPT_CCR_HALF 16
`define QPT_CCR_RIE 1
`define QPT_CCR_FIE 2
`define QPT_CCR_RFLAG 6
`define QPT_CCR_FFLAG 7
`define QPT_RST 32'h0000_0000
`endif

// ===== include/qpt_pkg.sv
// ****************************************
// shared types
// ****************************************
package qpt_pkg;
  typedef logic [15:0] qpt_cnt_t;
  // divider select codes of one channel
  typedef enum logic [2:0] {
    QPT_DIV2 = 3'h0,
    QPT_DIV4 = 3'h1,
    QPT_DIV8 = 3'h2,
    QPT_DIV16 = 3'h3,
    QPT_DIV1 = 3'h4
  } qpt_div_t;
endpackage : qpt_pkg

// ===== logic/qpt_clkgen.sv
`timescale 1ns/100ps
// ****************************************
// prescaler and two divider selectors of a pair
// ****************************************
module qpt_clkgen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // settings
  input wire logic [7:0] prescale,
  input wire logic [2:0] sel_a,
  input wire logic [2:0] sel_b,
  // channel clock ticks
  output logic [1:0] tick
);
  logic [7:0] pre_cnt_r;
  logic [3:0] div_r;
  logic pre_tick;

  // tick of one selector from the shared divider count
  function automatic logic sel_tick(input logic [2:0] sel, input logic [3:0] div, input logic pt);
    unique case (sel)
      qpt_pkg::QPT_DIV1: sel_tick = pt;
      qpt_pkg::QPT_DIV2: sel_tick = pt & div[0];
      qpt_pkg::QPT_DIV4: sel_tick = pt & (&div[1:0]);
      qpt_pkg::QPT_DIV8: sel_tick = pt & (&div[2:0]);
      qpt_pkg::QPT_DIV16: sel_tick = pt & (&div);
      default: sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  // zero stops the prescaler, else divide by value plus one
  assign pre_tick = (prescale != 8'h00) && (pre_cnt_r == prescale);

  // prescale counter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_r <= 8'h00;
    else if (prescale == 8'h00 || pre_tick)
      pre_cnt_r <= 8'h00;
    else
      pre_cnt_r <= pre_cnt_r + 8'h01;
  end

  // divider count shared by both selectors of the pair
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 4'h0;
    else if (pre_tick)
      div_r <= div_r + 4'h1;
  end

  assign tick[0] = sel_tick(sel_a, div_r, pre_tick);
  assign tick[1] = sel_tick(sel_b, div_r, pre_tick);
endmodule : qpt_clkgen

// ===== logic/qpt_deadzone.sv
`timescale 1ns/100ps
// ****************************************
// dead-zone generator for one channel pair
// ****************************************
module qpt_deadzone (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // source level and timing
  input wire logic lvl,
  input wire logic tick,
  input wire logic [7:0] len,
  // complementary outputs
  output logic out_a,
  output logic out_b
);
  logic lvl_q_r;
  logic [7:0] gap_r;

  // a level change restarts the gap, counted in channel clocks
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_q_r <= 1'b0;
      gap_r <= 8'h00;
    end
    else if (lvl != lvl_q_r)
    begin
      lvl_q_r <= lvl;
      gap_r <= len;
    end
    else if (tick && gap_r != 8'h00)
      gap_r <= gap_r - 8'h01;
  end

  // both outputs stay low during the gap, so each rise is delayed
  assign out_a = lvl_q_r & (gap_r == 8'h00);
  assign out_b = ~lvl_q_r & (gap_r == 8'h00);
endmodule : qpt_deadzone

// ===== verif/qpt_far_side.sv
`timescale 1ns/100ps
// ****************************************
// capture signal source on the far side
// ****************************************
module qpt_far_side (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // requests from the bench
  input wire logic [3:0] cap_req,
  input wire logic [7:0] lag,
  // capture pins
  output logic [3:0] cap_in
);
  logic [7:0] wait_r;
  // a requested level reaches the pins after lag plus one cycles, so slow sources are possible too
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r <= 8'h00;
      cap_in <= 4'h0;
    end
    else if (cap_req == cap_in)
      wait_r <= 8'h00;
    else if (wait_r >= lag)
      cap_in <= cap_req;
    else
      wait_r <= wait_r + 8'h01;
  end
endmodule : qpt_far_side

// ===== verif/qpt_pwm_timer_bench.sv
`timescale 1ns/100ps
// ****************************************
// self-checking bench
// ****************************************
module qpt_pwm_timer_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] lag = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  logic [63:0] note;
  logic [3:0] cap_in;
  logic [3:0] cap_req = 4'h0;
  logic [3:0] pwm_out;
  logic [3:0] irq;
  logic [63:0] exp_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int p;
  logic [7:0] zero_a[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40, 8'h44, 8'h50, 8'h7C, 8'h80, 8'hFC};
  qpt_pkg::qpt_div_t codes[5] = '{qpt_pkg::QPT_DIV1, qpt_pkg::QPT_DIV2,
    qpt_pkg::QPT_DIV4, qpt_pkg::QPT_DIV8, qpt_pkg::QPT_DIV16};

  // design and far side
  qpt_pwm_timer qpt_pwm_timer_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cap_in(cap_in),
    .pwm_out(pwm_out),
    .irq(irq)
  );
  qpt_far_side qpt_far_side_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cap_req(cap_req),
    .lag(lag),
    .cap_in(cap_in)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] ch_a(input int c, input logic [7:0] o);
    return 8'h0C + 8'(12 * c) + o;
  endfunction : ch_a

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // one write cycle, strobe dropped after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one read cycle; expected value and mask go to the queue
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // read data stand in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (rd_q)
    begin
      note = exp_q.pop_front();
      check(reg_rdata & note[63:32], note[31:0]);
    end
    rd_q <= reg_rd;
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(14));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, unmapped places read zero
    foreach (zero_a[i]) rd(zero_a[i], 32'h0);
    // buffers keep 16 bits, upper bits read zero
    for (int c = 0; c < 4; c++)
    begin
      v = $urandom;
      wr(ch_a(c, 8'h00), v);
      rd(ch_a(c, 8'h00), {16'h0, v[15:0]});
      wr(ch_a(c, 8'h04), ~v);
      rd(ch_a(c, 8'h04), {16'h0, ~v[15:0]});
    end
    // one-shot timing for each divider code, prescalers divide by two
    wr(8'h00, 32'h0000_0101);
    for (int i = 0; i < 5; i++)
    begin
      p = 2 << i;
      wr(8'h04, 32'(codes[i]) << (4 * (i % 4)));
      wr(ch_a(i % 4, 8'h00), 32'h3);
      wr(8'h40, 32'h1 << (i % 4));
      wr(8'h08, 32'h1 << (8 * (i % 4)));
      repeat (3 * p - 2) @(posedge sys_clk);
      #1 check(irq[i % 4], 1'b0);
      repeat (p + 8) @(posedge sys_clk);
      #1 check(irq[i % 4], 1'b1);
      rd(8'h44, 32'h1 << (i % 4));
      rd(ch_a(i % 4, 8'h08), 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h44, 32'h0);
      #1 check(irq[i % 4], 1'b0);
    end
    // pins stay inactive until their output enable is set
    wr(8'h08, 32'h0000_0400);
    repeat (2) @(posedge sys_clk);
    #1 check(pwm_out, 4'h0);
    wr(8'h7C, 32'hF);
    repeat (2) @(posedge sys_clk);
    #1 check(pwm_out, 4'h2);
    // channel 3 held by a stopped prescaler, buffers rewritten in mid-period
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h4000);
    wr(8'h08, 32'h0800_0400);
    wr(ch_a(3, 8'h04), 32'h2000);
    wr(ch_a(3, 8'h00), 32'h40);
    wr(8'h08, 32'h0900_0400);
    rd(ch_a(3, 8'h08), 32'h40);
    wr(ch_a(3, 8'h04), 32'h1);
    wr(ch_a(3, 8'h00), 32'hBEEF);
    wr(ch_a(3, 8'h08), 32'h5555);
    rd(ch_a(3, 8'h08), 32'h40);
    rd(ch_a(3, 8'h00), 32'hBEEF);
    #1 check(pwm_out[3], 1'b1);
    wr(8'h00, 32'h0000_0100);
    repeat (200) @(posedge sys_clk);
    rd(ch_a(3, 8'h08), 32'hBE00, 32'hFF00);
    rd(8'h44, 32'h8, 32'h8);
    #1 check(pwm_out[3], 1'b0);
    wr(8'h08, 32'h0000_0400);
    // dead zone on pair 0,1 with a gap of four channel clocks, pair 2,3 left alone
    wr(8'h00, 32'h0004_0101);
    wr(8'h08, 32'h0000_0414);
    repeat (3) @(posedge sys_clk);
    #1 check(pwm_out, 4'h0);
    repeat (20) @(posedge sys_clk);
    #1 check(pwm_out, 4'h1);
    // capture on channel 2, its timer set up first and its pin output off
    wr(8'h00, 32'h0);
    wr(ch_a(2, 8'h00), 32'h77);
    wr(8'h08, 32'h0001_0400);
    wr(ch_a(2, 8'h00), 32'h99);
    wr(8'h7C, 32'hB);
    wr(8'h78, 32'h4);
    wr(8'h54, 32'h2);
    cap_req <= 4'h4;
    repeat (8) @(posedge sys_clk);
    rd(8'h68, 32'h77);
    rd(8'h54, 32'h42);
    rd(ch_a(2, 8'h08), 32'h99);
    #1 check(irq[2], 1'b1);
    lag <= 8'h05;
    cap_req <= 4'h0;
    repeat (14) @(posedge sys_clk);
    rd(8'h6C, 32'h99);
    rd(8'h54, 32'hC2);
    wr(8'h54, 32'hC2);
    wr(8'h68, 32'h1111);
    rd(8'h54, 32'h2);
    rd(8'h68, 32'h77);
    #1 check(irq[2], 1'b0);
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule : qpt_pwm_timer_bench
